//--- hw/tif_defines.vh
// constants for the transmit interpolation filter chain
`ifndef TIF_DEFINES_VH
`define TIF_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, 8-bit address port)
// ----------------------------------------------------------------
`define TIF_OFS_CTRL 8'h00
`define TIF_OFS_COEF_ADDR 8'h04
`define TIF_OFS_COEF_LO 8'h08
`define TIF_OFS_COEF_HI 8'h0C
`define TIF_OFS_OVF_STATUS 8'h10
`define TIF_OFS_OVF_MASK 8'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TIF_CTRL_FIR_LO 0
`define TIF_CTRL_FIR_HI 1
`define TIF_CTRL_FIR_GAIN 2
`define TIF_CTRL_HB1_EN 3
`define TIF_CTRL_HB2_EN 4
`define TIF_CTRL_FIN_LO 5
`define TIF_CTRL_FIN_HI 6
`define TIF_CTRL_DAC_HALF 7
`define TIF_CTRL_TAPS_LO 8
`define TIF_CTRL_TAPS_HI 10
`define TIF_CTRL_RESET 16'h0000
`define TIF_CTRL_MASK 16'h07FF

// fir mode codes and final stage mode codes
`define TIF_FIR_BYPASS 2'h0
`define TIF_FIR_X1 2'h1
`define TIF_FIR_X2 2'h2
`define TIF_FIR_X4 2'h3
`define TIF_FIN_BYPASS 2'h0
`define TIF_FIN_X2 2'h1
`define TIF_FIN_X3 2'h2

// ----------------------------------------------------------------
// overflow status bits, reset values, arithmetic constants
// ----------------------------------------------------------------
`define TIF_OVF_FIR 0
`define TIF_OVF_HB1 1
`define TIF_OVF_HB2 2
`define TIF_OVF_FIN 3
`define TIF_OVF_RESET 4'h0
`define TIF_MASK_RESET 4'h0
`define TIF_TAPS_PER_CYCLE 16
`define TIF_MAX_GROUPS_X1 4'h4
`define TIF_FIR_SHIFT_0DB 14
`define TIF_FIR_SHIFT_M6DB 15
`define TIF_SAT_MAX 12'h7FF
`define TIF_SAT_MIN 12'h800

`endif

//--- hw/tif_chain.v
// transmit interpolation chain: programmable fir plus three fixed stages
//
// Notes on behaviour
// - 12-bit I/Q through four bypassable stages
// - every stage clamps overrange, never wraps
// - overrange sets readable status and pins
// - zero insertion first, then the filter
// - all timing from the master clock
// - fixed stages run at output rate
// - fir interpolates by 1, 2, 4 or bypass
// - 16-bit coefficients, 16 to 128 taps
// - fir gain 0 dB or -6 dB
// - each coefficient written as two bytes
// - fir clock is master or half
// - fir computes 16 taps per clock
// - at most 64 taps when interpolating by 1
// - first half-band: 15 taps, scale 8192
// - second half-band: 7 taps, scale 128
// - final stage by two: 1 2 1
// - final stage by three: 29 taps
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "tif_defines.vh"

// ----------------------------------------------------------------
// rate divider: passes every fac-th strobe
// ----------------------------------------------------------------
module tif_div (
  input wire clk,
  input wire rst,
  input wire en,
  input wire [2:0] fac,
  output wire hit
);
  reg [2:0] cnt_ff;

  assign hit = en & (cnt_ff == 3'h0);

  // wrap at fac-1 counted in faster strobes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 3'h0;
    end else if (en) begin
      if (cnt_ff + 3'h1 >= fac) begin
        cnt_ff <= 3'h0;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// fixed-coefficient interpolating stage, one channel
// ----------------------------------------------------------------
module tif_stage #(
  parameter ID = 0,
  parameter NT = 15,
  parameter SH = 13
) (
  input wire clk,
  input wire rst,
  input wire en_out,
  input wire en_in,
  input wire [11:0] din,
  output reg [11:0] dout,
  output reg ovf
);
  reg signed [11:0] dl_ff [0:NT-1];
  reg signed [39:0] acc;
  reg signed [39:0] scl;
  integer k;
  integer j;
  integer m;

  // folded coefficient set of each stage kind
  function signed [15:0] cf;
    input [4:0] i;
    begin
      cf = 16'h0000;
      case (ID)
        0: begin
          case (i)
            5'h00: cf = -16'h0035;
            5'h02: cf = 16'h0139;
            5'h04: cf = -16'h0483;
            5'h06: cf = 16'h137D;
            5'h07: cf = 16'h2000;
            default: cf = 16'h0000;
          endcase
        end
        1: begin
          case (i)
            5'h00: cf = -16'h0009;
            5'h02: cf = 16'h0049;
            5'h03: cf = 16'h0080;
            default: cf = 16'h0000;
          endcase
        end
        2: begin
          case (i)
            5'h00: cf = 16'h0001;
            5'h01: cf = 16'h0002;
            default: cf = 16'h0000;
          endcase
        end
        default: begin
          case (i)
            5'h00: cf = 16'h0024;
            5'h01: cf = -16'h0013;
            5'h03: cf = -16'h009C;
            5'h04: cf = -16'h000C;
            5'h06: cf = 16'h01DF;
            5'h07: cf = 16'h00DF;
            5'h09: cf = -16'h04BF;
            5'h0A: cf = -16'h03E1;
            5'h0C: cf = 16'h0DF1;
            5'h0D: cf = 16'h1885;
            5'h0E: cf = 16'h2000;
            default: cf = 16'h0000;
          endcase
        end
      endcase
    end
  endfunction

  // convolution over the zero-stuffed delay line
  always @* begin
    acc = 40'sh0;
    for (k = 0; k < NT; k = k + 1) begin
      j = (k < (NT + 1) / 2) ? k : NT - 1 - k;
      acc = acc + cf(j[4:0]) * dl_ff[k];
    end
    scl = acc >>> SH;
  end

  // insert sample or zero, then filter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (m = 0; m < NT; m = m + 1) begin
        dl_ff[m] <= 12'h000;
      end
      dout <= 12'h000;
      ovf <= 1'b0;
    end else if (en_out) begin
      dl_ff[0] <= en_in ? din : 12'h000;
      for (m = 1; m < NT; m = m + 1) begin
        dl_ff[m] <= dl_ff[m-1];
      end
      if (scl > 40'sd2047) begin
        dout <= `TIF_SAT_MAX;
        ovf <= 1'b1;
      end else if (scl < -40'sd2048) begin
        dout <= `TIF_SAT_MIN;
        ovf <= 1'b1;
      end else begin
        dout <= scl[11:0];
        ovf <= 1'b0;
      end
    end else begin
      ovf <= 1'b0;
    end
  end
endmodule

// ----------------------------------------------------------------
// top: registers, programmable fir, fixed stages, dac port
// ----------------------------------------------------------------
module tif_chain #(
  parameter NTAP = 128
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_ff,
  input wire [11:0] tx_i,
  input wire [11:0] tx_q,
  input wire tx_frame,
  output reg in_req_ff,
  output reg [11:0] dac_i_ff,
  output reg [11:0] dac_q_ff,
  output reg dac_strobe_ff,
  output reg [3:0] ovf_pins_ff,
  output reg irq_ff
);
  reg [15:0] ctrl_ff;
  reg [6:0] coef_addr_ff;
  reg [7:0] coef_lo_ff;
  reg [15:0] coef_mem [0:NTAP-1];
  reg [3:0] sts_ff;
  reg [3:0] mask_ff;
  reg [3:0] nxt_sts;
  reg half_ff;
  reg [11:0] hold_i_ff;
  reg [11:0] hold_q_ff;
  reg signed [11:0] dl_i [0:NTAP-1];
  reg signed [11:0] dl_q [0:NTAP-1];
  reg signed [35:0] acc_i_ff;
  reg signed [35:0] acc_q_ff;
  reg [3:0] grp_ff;
  reg [11:0] fir_i_ff;
  reg [11:0] fir_q_ff;
  reg fir_ovf_ff;
  reg signed [35:0] gs_i;
  reg signed [35:0] gs_q;
  reg signed [35:0] sc_i;
  reg signed [35:0] sc_q;
  reg [3:0] ngrp;
  reg [2:0] fir_fac;
  reg [2:0] fin_fac;
  reg [31:0] rval;
  reg fir_o_i;
  reg fir_o_q;
  reg [11:0] fir_s_i;
  reg [11:0] fir_s_q;
  integer k;
  integer m;
  wire [1:0] fir_mode = ctrl_ff[`TIF_CTRL_FIR_HI:`TIF_CTRL_FIR_LO];
  wire [1:0] fin_mode = ctrl_ff[`TIF_CTRL_FIN_HI:`TIF_CTRL_FIN_LO];
  wire hb1_on = ctrl_ff[`TIF_CTRL_HB1_EN];
  wire hb2_on = ctrl_ff[`TIF_CTRL_HB2_EN];
  wire fir_on = (fir_mode != `TIF_FIR_BYPASS);
  wire fin_on = (fin_mode == `TIF_FIN_X2) || (fin_mode == `TIF_FIN_X3);
  wire dac_en;
  wire e3o;
  wire e2o;
  wire fo;
  wire fi;
  wire [11:0] s1_i;
  wire [11:0] s1_q;
  wire [11:0] h1_i;
  wire [11:0] h1_q;
  wire [11:0] h2_i;
  wire [11:0] h2_q;
  wire [11:0] b2_i;
  wire [11:0] b2_q;
  wire [11:0] b3_i;
  wire [11:0] b3_q;
  wire [11:0] s2_i;
  wire [11:0] s2_q;
  wire [11:0] s3_i;
  wire [11:0] s3_q;
  wire [11:0] s4_i;
  wire [11:0] s4_q;
  wire [7:0] so;
  wire [3:0] ev;

  // ----------------------------------------------------------------
  // strobe chain derived from the master clock
  // ----------------------------------------------------------------

  // dac strobe every cycle or every second cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
    end
  end
  // every stage strobe comes from clk
  assign dac_en = ~ctrl_ff[`TIF_CTRL_DAC_HALF] | half_ff;

  // interpolation factors per stage, bypass counts as one
  always @* begin
    case (fir_mode)
      `TIF_FIR_X2: fir_fac = 3'h2;
      `TIF_FIR_X4: fir_fac = 3'h4;
      default: fir_fac = 3'h1;
    endcase
    case (fin_mode)
      `TIF_FIN_X2: fin_fac = 3'h2;
      `TIF_FIN_X3: fin_fac = 3'h3;
      default: fin_fac = 3'h1;
    endcase
    // 16 taps per group, one to eight groups
    ngrp = {1'b0, ctrl_ff[`TIF_CTRL_TAPS_HI:`TIF_CTRL_TAPS_LO]} + 4'h1;
    if (fir_fac == 3'h1 && ngrp > `TIF_MAX_GROUPS_X1) begin
      ngrp = `TIF_MAX_GROUPS_X1;
    end
  end

  // rates chain back from the dac strobe
  tif_div u_div4 (.clk(clk), .rst(rst), .en(dac_en), .fac(fin_fac), .hit(e3o));
  tif_div u_div3 (.clk(clk), .rst(rst), .en(e3o), .fac(hb2_on ? 3'h2 : 3'h1),
    .hit(e2o));
  tif_div u_div2 (.clk(clk), .rst(rst), .en(e2o), .fac(hb1_on ? 3'h2 : 3'h1),
    .hit(fo));
  tif_div u_div1 (.clk(clk), .rst(rst), .en(fo), .fac(fir_fac), .hit(fi));

  // ----------------------------------------------------------------
  // sample intake
  // ----------------------------------------------------------------

  // request a sample, capture 12-bit I and Q next cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_req_ff <= 1'b0;
      hold_i_ff <= 12'h000;
      hold_q_ff <= 12'h000;
    end else begin
      in_req_ff <= fi;
      if (in_req_ff) begin
        hold_i_ff <= tx_frame ? tx_i : 12'h000; // frame low sends zeros
        hold_q_ff <= tx_frame ? tx_q : 12'h000;
      end
    end
  end

  // ----------------------------------------------------------------
  // programmable polyphase fir
  // ----------------------------------------------------------------

  // sixteen taps summed per dac strobe
  always @* begin
    gs_i = 36'sh0;
    gs_q = 36'sh0;
    for (k = 0; k < `TIF_TAPS_PER_CYCLE; k = k + 1) begin
      gs_i = gs_i + $signed(coef_mem[{grp_ff[2:0], k[3:0]}]) * dl_i[{grp_ff[2:0], k[3:0]}];
      gs_q = gs_q + $signed(coef_mem[{grp_ff[2:0], k[3:0]}]) * dl_q[{grp_ff[2:0], k[3:0]}];
    end
    // gain 0 dB or -6 dB
    if (ctrl_ff[`TIF_CTRL_FIR_GAIN]) begin
      sc_i = acc_i_ff >>> `TIF_FIR_SHIFT_M6DB;
      sc_q = acc_q_ff >>> `TIF_FIR_SHIFT_M6DB;
    end else begin
      sc_i = acc_i_ff >>> `TIF_FIR_SHIFT_0DB;
      sc_q = acc_q_ff >>> `TIF_FIR_SHIFT_0DB;
    end
    fir_o_i = (sc_i > 36'sd2047) || (sc_i < -36'sd2048);
    fir_o_q = (sc_q > 36'sd2047) || (sc_q < -36'sd2048);
    fir_s_i = fir_o_i ? (sc_i[35] ? `TIF_SAT_MIN : `TIF_SAT_MAX) : sc_i[11:0];
    fir_s_q = fir_o_q ? (sc_q[35] ? `TIF_SAT_MIN : `TIF_SAT_MAX) : sc_q[11:0];
  end

  // zero-stuff at output rate, accumulate groups after
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (m = 0; m < NTAP; m = m + 1) begin
        dl_i[m] <= 12'h000;
        dl_q[m] <= 12'h000;
      end
      acc_i_ff <= 36'sh0;
      acc_q_ff <= 36'sh0;
      grp_ff <= 4'h0;
      fir_i_ff <= 12'h000;
      fir_q_ff <= 12'h000;
      fir_ovf_ff <= 1'b0;
    end else if (fo) begin
      fir_i_ff <= fir_s_i;
      fir_q_ff <= fir_s_q;
      fir_ovf_ff <= fir_on & (fir_o_i | fir_o_q);
      dl_i[0] <= fi ? hold_i_ff : 12'h000;
      dl_q[0] <= fi ? hold_q_ff : 12'h000;
      for (m = 1; m < NTAP; m = m + 1) begin
        dl_i[m] <= dl_i[m-1];
        dl_q[m] <= dl_q[m-1];
      end
      acc_i_ff <= 36'sh0;
      acc_q_ff <= 36'sh0;
      grp_ff <= 4'h0;
    end else begin
      fir_ovf_ff <= 1'b0;
      // groups advance on the dac strobe
      if (dac_en && grp_ff < ngrp) begin
        acc_i_ff <= acc_i_ff + gs_i;
        acc_q_ff <= acc_q_ff + gs_q;
        grp_ff <= grp_ff + 4'h1;
      end
    end
  end

  // bypassed fir passes the input sample
  assign s1_i = fir_on ? fir_i_ff : hold_i_ff;
  assign s1_q = fir_on ? fir_q_ff : hold_q_ff;

  // ----------------------------------------------------------------
  // fixed stages, I and Q each
  // ----------------------------------------------------------------

  // first half-band at twice its input rate
  tif_stage #(.ID(0), .NT(15), .SH(13)) u_hb1_i (.clk(clk), .rst(rst),
    .en_out(e2o), .en_in(fo), .din(s1_i), .dout(h1_i), .ovf(so[0]));
  tif_stage #(.ID(0), .NT(15), .SH(13)) u_hb1_q (.clk(clk), .rst(rst),
    .en_out(e2o), .en_in(fo), .din(s1_q), .dout(h1_q), .ovf(so[1]));
  assign s2_i = hb1_on ? h1_i : s1_i;
  assign s2_q = hb1_on ? h1_q : s1_q;

  tif_stage #(.ID(1), .NT(7), .SH(7)) u_hb2_i (.clk(clk), .rst(rst),
    .en_out(e3o), .en_in(e2o), .din(s2_i), .dout(h2_i), .ovf(so[2]));
  tif_stage #(.ID(1), .NT(7), .SH(7)) u_hb2_q (.clk(clk), .rst(rst),
    .en_out(e3o), .en_in(e2o), .din(s2_q), .dout(h2_q), .ovf(so[3]));
  assign s3_i = hb2_on ? h2_i : s2_i;
  assign s3_q = hb2_on ? h2_q : s2_q;

  tif_stage #(.ID(2), .NT(3), .SH(1)) u_by2_i (.clk(clk), .rst(rst),
    .en_out(dac_en), .en_in(e3o), .din(s3_i), .dout(b2_i), .ovf(so[4]));
  tif_stage #(.ID(2), .NT(3), .SH(1)) u_by2_q (.clk(clk), .rst(rst),
    .en_out(dac_en), .en_in(e3o), .din(s3_q), .dout(b2_q), .ovf(so[5]));
  tif_stage #(.ID(3), .NT(29), .SH(13)) u_by3_i (.clk(clk), .rst(rst),
    .en_out(dac_en), .en_in(e3o), .din(s3_i), .dout(b3_i), .ovf(so[6]));
  tif_stage #(.ID(3), .NT(29), .SH(13)) u_by3_q (.clk(clk), .rst(rst),
    .en_out(dac_en), .en_in(e3o), .din(s3_q), .dout(b3_q), .ovf(so[7]));
  assign s4_i = (fin_mode == `TIF_FIN_X3) ? b3_i : (fin_mode == `TIF_FIN_X2) ? b2_i : s3_i;
  assign s4_q = (fin_mode == `TIF_FIN_X3) ? b3_q : (fin_mode == `TIF_FIN_X2) ? b2_q : s3_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_i_ff <= 12'h000;
      dac_q_ff <= 12'h000;
      dac_strobe_ff <= 1'b0;
    end else begin
      dac_strobe_ff <= dac_en;
      if (dac_en) begin
        dac_i_ff <= s4_i;
        dac_q_ff <= s4_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // overflow events, status, interrupt
  // ----------------------------------------------------------------

  // per-stage events, ignored while a stage is bypassed
  assign ev[`TIF_OVF_FIR] = fir_ovf_ff;
  assign ev[`TIF_OVF_HB1] = hb1_on & (so[0] | so[1]);
  assign ev[`TIF_OVF_HB2] = hb2_on & (so[2] | so[3]);
  assign ev[`TIF_OVF_FIN] = ((fin_mode == `TIF_FIN_X2) & (so[4] | so[5])) |
    ((fin_mode == `TIF_FIN_X3) & (so[6] | so[7]));

  // sticky status, write one clears, a new event wins
  always @* begin
    nxt_sts = sts_ff;
    if (wr && addr == `TIF_OFS_OVF_STATUS) begin
      nxt_sts = nxt_sts & ~wdata[3:0];
    end
    nxt_sts = nxt_sts | ev;
  end

  // status, pins and interrupt follow overrange
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sts_ff <= `TIF_OVF_RESET;
      ovf_pins_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      ovf_pins_ff <= ev;
      irq_ff <= |(nxt_sts & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------

  // control, mask and coefficient writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `TIF_CTRL_RESET;
      mask_ff <= `TIF_MASK_RESET;
      coef_addr_ff <= 7'h00;
      coef_lo_ff <= 8'h00;
    end else if (wr) begin
      case (addr)
        `TIF_OFS_CTRL: ctrl_ff <= wdata[15:0] & `TIF_CTRL_MASK;
        `TIF_OFS_OVF_MASK: mask_ff <= wdata[3:0];
        `TIF_OFS_COEF_ADDR: coef_addr_ff <= wdata[6:0];
        `TIF_OFS_COEF_LO: coef_lo_ff <= wdata[7:0];
        default: coef_lo_ff <= coef_lo_ff;
      endcase
    end
  end

  // high byte write commits the 16-bit word
  always @(posedge clk) begin
    if (wr && addr == `TIF_OFS_COEF_HI) begin
      coef_mem[coef_addr_ff] <= {wdata[7:0], coef_lo_ff};
    end
  end

  // read mux, unmapped reads return zero
  always @* begin
    case (addr)
      `TIF_OFS_CTRL: rval = {16'h0000, ctrl_ff};
      `TIF_OFS_COEF_ADDR: rval = {25'h000_0000, coef_addr_ff};
      `TIF_OFS_COEF_LO: rval = {24'h00_0000, coef_mem[coef_addr_ff][7:0]};
      `TIF_OFS_COEF_HI: rval = {24'h00_0000, coef_mem[coef_addr_ff][15:8]};
      `TIF_OFS_OVF_STATUS: rval = {28'h000_0000, sts_ff};
      `TIF_OFS_OVF_MASK: rval = {28'h000_0000, mask_ff};
      default: rval = 32'h0000_0000;
    endcase
  end

  // read data stands one cycle after the strobe only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= rd ? rval : 32'h0000_0000;
    end
  end
endmodule

//--- dv/tif_bb_model.sv
// baseband sample source that answers the chain's sample requests
`timescale 1ns/100ps

module tif_bb_model (
  input wire clk,
  input wire rst,
  input wire in_req_ff,
  input wire frame_on,
  input wire [11:0] smp_i,
  input wire [11:0] smp_q,
  output logic [11:0] tx_i,
  output logic [11:0] tx_q,
  output logic tx_frame
);
  // ----------------------------------------
  // sample drive
  // ----------------------------------------
  // paired 12-bit samples
  // sample only while the request stands, inverted junk otherwise
  assign tx_i = in_req_ff ? smp_i : ~smp_i;
  assign tx_q = in_req_ff ? smp_q : ~smp_q;

  // frame level follows the bench one cycle late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_frame <= 1'b0;
    end else begin
      tx_frame <= frame_on;
    end
  end
endmodule

//--- dv/tif_chain_assertions.sv
// port checker for the interpolation chain
`timescale 1ns/100ps
`include "tif_defines.vh"

module tif_chain_assert #(
  parameter NTAP = 128
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata_ff,
  input wire in_req_ff,
  input wire [11:0] dac_i_ff,
  input wire [11:0] dac_q_ff,
  input wire dac_strobe_ff,
  input wire [3:0] ovf_pins_ff,
  input wire irq_ff
);
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  reg [10:0] ctrl_ff;
  reg [3:0] mask_ff;
  reg [7:0] calm_ff;
  reg [7:0] gap_ff;
  reg [2:0] mz_ff;
  reg [2:0] hit_ff;
  wire ctrl_wr = wr && addr == `TIF_OFS_CTRL;
  wire irq_wr = wr && (addr == `TIF_OFS_OVF_STATUS || addr == `TIF_OFS_OVF_MASK);
  wire [7:0] f_fir = ctrl_ff[1:0] == 2'h2 ? 8'h02 : ctrl_ff[1:0] == 2'h3 ? 8'h04 : 8'h01;
  wire [7:0] f_fin = ctrl_ff[6:5] == 2'h1 ? 8'h02 : ctrl_ff[6:5] == 2'h2 ? 8'h03 : 8'h01;
  wire [7:0] f_hb = (ctrl_ff[3] ? 8'h02 : 8'h01) * (ctrl_ff[4] ? 8'h02 : 8'h01);
  wire [7:0] per = f_fir * f_fin * f_hb * (ctrl_ff[7] ? 8'h02 : 8'h01);

  // follow config writes, count quiet cycles and request gaps
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 11'h000;
      mask_ff <= 4'h0;
      calm_ff <= 8'h00;
      gap_ff <= 8'h00;
      mz_ff <= 3'h7;
      hit_ff <= 3'h0;
    end else begin
      if (ctrl_wr)
        ctrl_ff <= wdata[10:0];
      if (wr && addr == `TIF_OFS_OVF_MASK)
        mask_ff <= wdata[3:0];
      calm_ff <= ctrl_wr ? 8'h00 : calm_ff + {7'h00, calm_ff != 8'hFF};
      gap_ff <= in_req_ff ? 8'h01 : gap_ff + {7'h00, gap_ff != 8'hFF};
      mz_ff <= {mz_ff[1:0], mask_ff == 4'h0};
      hit_ff <= {hit_ff[1:0], irq_wr || ovf_pins_ff != 4'h0};
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_ctrl;
    rd && addr == `TIF_OFS_CTRL;
  endsequence
  sequence s_rd_mask;
    rd && addr == `TIF_OFS_OVF_MASK;
  endsequence

  chk_rdata_idle:
  assert property (!$past(rd) |-> rdata_ff == 32'h0) else $error("stray read data");
  chk_ctrl_back:
  assert property (s_rd_ctrl |=> rdata_ff == {21'h00_0000, ctrl_ff}) else $error("ctrl readback");
  chk_mask_back:
  assert property (s_rd_mask |=> rdata_ff == {28'h000_0000, mask_ff}) else $error("mask readback");
  chk_void_read:
  assert property (rd && addr > 8'h14 |=> rdata_ff == 32'h0) else $error("unmapped read");
  chk_dac_full:
  assert property (calm_ff > 8'h03 && !ctrl_ff[7] |-> dac_strobe_ff) else $error("full rate");
  chk_dac_half:
  assert property (calm_ff > 8'h03 && ctrl_ff[7] |-> dac_strobe_ff != $past(dac_strobe_ff))
    else $error("half rate");
  chk_dac_hold:
  assert property (!dac_strobe_ff |-> $stable(dac_i_ff) && $stable(dac_q_ff))
    else $error("dac moved off strobe");
  chk_req_period:
  assert property (in_req_ff && calm_ff > 8'hC8 |-> gap_ff == per) else $error("request period");
  chk_irq_masked:
  assert property (&mz_ff |-> !irq_ff) else $error("irq while masked");
  chk_irq_cause:
  assert property (irq_ff != $past(irq_ff) |-> hit_ff != 3'h0 || ovf_pins_ff != 4'h0)
    else $error("irq moved alone");
endmodule

//--- dv/tif_chain_tb.sv
// self-checking bench for the interpolation chain
`timescale 1ns/100ps
`include "tif_defines.vh"

module tif_chain_tb;
  logic clk, rst, wr, rd, frame_on;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [11:0] smp_i, smp_q;
  wire [31:0] rdata_ff;
  wire [11:0] tx_i, tx_q, dac_i_ff, dac_q_ff;
  wire tx_frame, in_req_ff, dac_strobe_ff, irq_ff;
  wire [3:0] ovf_pins_ff;
  int error_cnt;
  int samples_checked;

  tif_chain tif_chain_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .tx_i(tx_i), .tx_q(tx_q), .tx_frame(tx_frame),
    .in_req_ff(in_req_ff), .dac_i_ff(dac_i_ff), .dac_q_ff(dac_q_ff),
    .dac_strobe_ff(dac_strobe_ff), .ovf_pins_ff(ovf_pins_ff), .irq_ff(irq_ff)
  );
  tif_bb_model tif_bb_model_inst (
    .clk(clk), .rst(rst), .in_req_ff(in_req_ff), .frame_on(frame_on),
    .smp_i(smp_i), .smp_q(smp_q), .tx_i(tx_i), .tx_q(tx_q), .tx_frame(tx_frame)
  );

  // free-running master clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmpn(input logic [11:0] g, input logic [11:0] e, input int t);
    int d;
    d = int'($signed(g)) - int'($signed(e));
    samples_checked++;
    if ($isunknown(g) || d > t || d < -t) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata_ff, e);
  endtask
  task automatic dc_chk(input logic [11:0] ei, input logic [11:0] eq, input int t);
    repeat (8) begin
      @(posedge clk);
      #1;
      cmpn(dac_i_ff, ei, t);
      cmpn(dac_q_ff, eq, t);
    end
  endtask
  task automatic fill(input logic [15:0] c, input int n);
    for (int k = 0; k < n; k++) begin
      wreg(`TIF_OFS_COEF_ADDR, k);
      wreg(`TIF_OFS_COEF_LO, {24'h00_0000, c[7:0]});
      wreg(`TIF_OFS_COEF_HI, {24'h00_0000, c[15:8]});
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rchk(`TIF_OFS_CTRL, 32'h0);
    rchk(`TIF_OFS_OVF_STATUS, 32'h0);
    rchk(`TIF_OFS_OVF_MASK, 32'h0);
    rchk(8'h18, 32'h0);
    wreg(`TIF_OFS_CTRL, 32'hFFFF_F800);
    rchk(`TIF_OFS_CTRL, 32'h0);
  endtask
  task automatic t_pass;
    smp_i <= 12'h123;
    smp_q <= 12'hEDC;
    tick(20);
    dc_chk(12'h123, 12'hEDC, 0);
    frame_on <= 1'b0;
    tick(20);
    dc_chk(12'h000, 12'h000, 0);
    frame_on <= 1'b1;
  endtask
  task automatic t_stages;
    logic [31:0] cfg [5] = '{32'h08, 32'h10, 32'h20, 32'h40, 32'hB8};
    int tol [5] = '{1, 0, 0, 1, 2};
    smp_i <= 12'h400;
    smp_q <= 12'hC00;
    foreach (cfg[k]) begin
      wreg(`TIF_OFS_CTRL, cfg[k]);
      tick(300);
      dc_chk(12'h400, 12'hC00, tol[k]);
    end
  endtask
  task automatic t_fir;
    logic [31:0] cfg [4] = '{32'h31, 32'h35, 32'h32, 32'h33};
    logic [15:0] cf [4] = '{16'h0400, 16'h0400, 16'h0800, 16'h1000};
    logic [11:0] ex [4] = '{12'h400, 12'h200, 12'h400, 12'h400};
    foreach (cfg[k]) begin
      fill(cf[k], 16);
      wreg(`TIF_OFS_CTRL, cfg[k]);
      tick(400);
      dc_chk(ex[k], -ex[k], 0);
    end
    rchk(`TIF_OFS_COEF_LO, 32'h00);
    rchk(`TIF_OFS_COEF_HI, 32'h10);
    fill(16'h0100, 128);
    wreg(`TIF_OFS_CTRL, 32'h739);
    tick(900);
    dc_chk(12'h400, 12'hC00, 1);
  endtask
  task automatic t_ovf;
    logic seen;
    seen = 1'b0;
    fill(16'h7FFF, 16);
    wreg(`TIF_OFS_CTRL, 32'h31);
    smp_i <= 12'h7FF;
    smp_q <= 12'h800;
    repeat (400) begin
      @(posedge clk);
      #1;
      seen = seen | ovf_pins_ff[0];
    end
    cmp({31'h0, seen}, 32'h1);
    wreg(`TIF_OFS_OVF_STATUS, 32'hF);
    dc_chk(12'h7FF, 12'h800, 0);
    rchk(`TIF_OFS_OVF_STATUS, 32'h1);
    cmp({31'h0, irq_ff}, 32'h0);
    wreg(`TIF_OFS_OVF_MASK, 32'h1);
    tick(2);
    #1;
    cmp({31'h0, irq_ff}, 32'h1);
    frame_on <= 1'b0;
    tick(400);
    wreg(`TIF_OFS_OVF_STATUS, 32'hF);
    rchk(`TIF_OFS_OVF_STATUS, 32'h0);
    cmp({31'h0, irq_ff}, 32'h0);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    smp_i = 12'h000;
    smp_q = 12'h000;
    frame_on = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pass;
    t_stages;
    t_fir;
    t_ovf;
    end_of_test;
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end
endmodule

bind tif_chain tif_chain_assert #(.NTAP(NTAP)) tif_chain_assert_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_ff(rdata_ff), .in_req_ff(in_req_ff), .dac_i_ff(dac_i_ff),
  .dac_q_ff(dac_q_ff), .dac_strobe_ff(dac_strobe_ff),
  .ovf_pins_ff(ovf_pins_ff), .irq_ff(irq_ff)
);
